// file: core/bist_lane_error.sv
// Purpose: Records first error lane, error tally and per-lane flags
// Assumes: Lane vector already masked; bit order follows the mask register
// Notes: Hardware set wins over a software clear in the same cycle
`timescale 1ns/1ps
module bist_lane_error (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [17:0] lane_fail,
  input wire logic clear_lane,
  input wire logic clear_tally,
  input wire logic flags_write,
  input wire logic [17:0] flags_wdata,
  output logic [4:0] first_error_lane,
  output logic [10:0] error_tally,
  output logic [17:0] lane_error_flags
);
  logic any_fail;
  logic lane_seen;
  logic [4:0] top_lane;

  // Register bit position equals the lane code, so the top set bit is the code
  function automatic logic [4:0] top_bit(input logic [17:0] v);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 0; i < bist_pkg::lane_count; i++) begin
      if (v[i]) r = 5'(i);
    end
    return r;
  endfunction

  assign any_fail = |lane_fail;
  assign top_lane = top_bit(lane_fail);

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      first_error_lane <= 5'h00;
      lane_seen <= 1'b0;
      error_tally <= 11'h000;
      lane_error_flags <= 18'h00000;
    end else begin
      if (any_fail && (!lane_seen || clear_lane)) begin
        first_error_lane <= top_lane;
        lane_seen <= 1'b1;
      end else if (clear_lane) begin
        first_error_lane <= 5'h00;
        lane_seen <= 1'b0;
      end
      if (any_fail) begin
        // Saturate; a clear in the same cycle still counts the new error
        if (clear_tally) error_tally <= 11'h001;
        else if (error_tally != bist_pkg::tally_max) error_tally <= error_tally + 11'h001;
      end else if (clear_tally) begin
        error_tally <= 11'h000;
      end
      lane_error_flags <= (flags_write ? (lane_error_flags & flags_wdata) : lane_error_flags)
        | lane_fail;
    end
  end

  a_tally_saturates: assert property (@(posedge sys_clk) disable iff (!nrst)
    error_tally == bist_pkg::tally_max && !clear_tally |=> error_tally == bist_pkg::tally_max)
    else $error("tally wrapped");
  a_tally_counts_up: assert property (@(posedge sys_clk) disable iff (!nrst)
    any_fail && !clear_tally && error_tally != bist_pkg::tally_max
    |=> error_tally == $past(error_tally) + 11'h001) else $error("tally missed");
  a_first_lane_held: assert property (@(posedge sys_clk) disable iff (!nrst)
    lane_seen && !clear_lane |=> $stable(first_error_lane)) else $error("lane moved");
  a_first_lane_load: assert property (@(posedge sys_clk) disable iff (!nrst)
    !lane_seen && any_fail |=> first_error_lane == $past(top_lane))
    else $error("lane not loaded");
  a_flag_sticky: assert property (@(posedge sys_clk) disable iff (!nrst)
    any_fail |=> (lane_error_flags & $past(lane_fail)) == $past(lane_fail))
    else $error("flag lost");
  a_lane_code_legal: assert property (@(posedge sys_clk) disable iff (!nrst)
    first_error_lane <= 5'd17) else $error("reserved lane code");
  c_tally_full: cover property (@(posedge sys_clk) error_tally == bist_pkg::tally_max);
endmodule

// file: core/bist_pattern_gen.sv
// Purpose: Sequences buffer, modulo and constant generators into loops
// Assumes: One pattern bit per lane per cycle
// Notes: A loop ends after the third generator; rotation hooks on loop_end
`timescale 1ns/1ps
module bist_pattern_gen (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic run,
  input wire logic [31:0] sequence_ctl,
  output logic [1:0] gen,
  output logic [5:0] bit_index,
  output logic idle_bit,
  output logic loop_end
);
  logic [1:0] slot;
  logic [9:0] rep;
  logic [2:0] order;
  logic [6:0] buf_reps;
  logic [6:0] mod_reps;
  logic [4:0] const_reps;
  logic [5:0] bit_len;
  logic [9:0] reps_now;
  logic last_bit;
  logic last_rep;
  logic [1:0] g0;
  logic [1:0] g1;
  logic [1:0] g2;

  assign order = sequence_ctl[bist_pkg::seq_order_lo +: 3];
  assign buf_reps = sequence_ctl[bist_pkg::seq_buf_lo +: 7];
  assign mod_reps = sequence_ctl[bist_pkg::seq_modulo_repeat_count_lo +: 7];
  assign const_reps = sequence_ctl[bist_pkg::seq_constant_repeat_count_lo +: 5];

  // Order table; reserved codes give an order of no defined meaning
  assign g0 = (order[2]) ? bist_pkg::gen_constant :
    (order[1]) ? bist_pkg::gen_modulo : bist_pkg::gen_buffer;
  assign g1 = (order == 3'h0 || order == 3'h5) ? bist_pkg::gen_modulo :
    (order == 3'h1 || order == 3'h3) ? bist_pkg::gen_constant : bist_pkg::gen_buffer;
  assign g2 = (order == 3'h0 || order == 3'h2) ? bist_pkg::gen_constant :
    (order == 3'h1 || order == 3'h4) ? bist_pkg::gen_modulo : bist_pkg::gen_buffer;
  assign gen = (slot == 2'h0) ? g0 : (slot == 2'h1) ? g1 : g2;

  assign bit_len = (gen == bist_pkg::gen_buffer) ? 6'(bist_pkg::store_bits) :
    6'(bist_pkg::pattern_bits);
  assign reps_now = (gen == bist_pkg::gen_buffer) ? {3'h0, buf_reps} :
    (gen == bist_pkg::gen_modulo) ? {3'h0, mod_reps} : {5'h00, const_reps};
  // A zero count skips the generator; idle_bit marks those filler cycles
  assign idle_bit = (reps_now == 10'h000);
  assign last_bit = idle_bit || (bit_index == bit_len - 6'h01);
  assign last_rep = idle_bit || (rep == reps_now - 10'h001);
  assign loop_end = run && last_bit && last_rep && (slot == 2'h2);

  always_ff @(posedge sys_clk) begin
    if (!nrst || !run) begin
      slot <= 2'h0;
      rep <= 10'h000;
      bit_index <= 6'h00;
    end else if (last_bit) begin
      bit_index <= 6'h00;
      if (last_rep) begin
        rep <= 10'h000;
        slot <= (slot == 2'h2) ? 2'h0 : slot + 2'h1;
      end else begin
        rep <= rep + 10'h001;
      end
    end else begin
      bit_index <= bit_index + 6'h01;
    end
  end

  a_loop_slot_range: assert property (@(posedge sys_clk) disable iff (!nrst)
    slot != 2'h3) else $error("slot out of range");
  a_loop_restart: assert property (@(posedge sys_clk) disable iff (!nrst)
    loop_end |=> slot == 2'h0) else $error("loop did not restart");
endmodule

// file: core/bist_pkg.sv
// Purpose: Shared constants for the link lane self-test engine
// Assumes: 32-bit register bus, 18 lanes
// Notes: Offsets are byte addresses of aligned words
package bist_pkg;
  localparam int lane_count = 18;
  localparam int pattern_bits = 24;
  localparam int store_bits = 40;
  // Register byte offsets
  localparam logic [5:0] off_control = 6'h00;
  localparam logic [5:0] off_sequence = 6'h04;
  localparam logic [5:0] off_store_one = 6'h08;
  localparam logic [5:0] off_mask = 6'h0c;
  localparam logic [5:0] off_inversion = 6'h10;
  localparam logic [5:0] off_store_two = 6'h14;
  localparam logic [5:0] off_store_two_sel = 6'h18;
  localparam logic [5:0] off_store_upper = 6'h1c;
  localparam logic [5:0] off_scramble = 6'h20;
  localparam logic [5:0] off_lane_error = 6'h24;
  localparam logic [5:0] off_run = 6'h28;
  // Control register fields
  localparam int ctl_width_bit = 31;
  localparam int ctl_tally_lo = 16;
  localparam int ctl_lane_lo = 8;
  localparam int ctl_rot_bit = 5;
  localparam logic [10:0] tally_max = 11'h7ff;
  localparam logic [4:0] lane_ones = 5'h1f;
  // Sequence register fields
  localparam int seq_order_lo = 0;
  localparam int seq_buf_lo = 3;
  localparam int seq_mod_lo = 10;
  localparam int seq_modulo_repeat_count_lo = 13;
  localparam int seq_const_bit = 20;
  localparam int seq_constant_repeat_count_lo = 21;
  // Reset values
  localparam logic [17:0] mask_reset = 18'h3ffff;
  localparam logic [23:0] store_one_reset = 24'h5a5a5a;
  localparam logic [23:0] store_two_reset = 24'ha5a5a5;
  localparam logic [31:0] store_upper_reset = 32'h0f0ff0f0;
  localparam logic [22:0] scramble_seed = 23'h7fffff;
  // Engine width: 1 means 18-lane engine
  localparam logic engine_wide = 1'b1;
  // Modulo patterns
  localparam logic [23:0] mod_l2 = 24'h555555;
  localparam logic [23:0] mod_l4 = 24'h333333;
  localparam logic [23:0] mod_l6 = 24'h1c71c7;
  localparam logic [23:0] mod_l8 = 24'h0f0f0f;
  localparam logic [23:0] mod_l24 = 24'h000fff;
  typedef enum logic [1:0] {
    gen_buffer = 2'b00,
    gen_modulo = 2'b01,
    gen_constant = 2'b10
  } gen_type;
endpackage

// file: core/link_lane_bist_engine.sv
// Purpose: Link lane self-test engine with AXI4-Lite register access
// Assumes: 100 MHz sys_clk, synchronous active-low nrst, 18 lanes
// Notes: Run bit and lane-half selector are local registers
`timescale 1ns/1ps
module link_lane_bist_engine (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [5:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [5:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic narrow_engine,
  input wire logic [1:0] link_width,
  output logic [17:0] tx_lanes,
  input wire logic [17:0] rx_lanes
);
  logic [31:0] sequence_ctl;
  logic [23:0] store_one;
  logic [23:0] store_two;
  logic [31:0] store_upper;
  logic [17:0] lane_mask;
  logic [17:0] lane_inversion;
  logic [17:0] store_two_lane_select;
  logic [17:0] lane_scramble;
  logic inversion_rotate_enable;
  logic run;
  logic [1:0] lane_half_selector;
  logic [4:0] first_error_lane;
  logic [10:0] error_tally;
  logic [17:0] lane_error_flags;
  logic [1:0] gen;
  logic [5:0] bit_index;
  logic idle_bit;
  logic loop_end;
  logic [22:0] scram_state;
  logic [17:0] rx_meta;
  logic [17:0] rx_sync;
  logic [17:0] expect_d1;
  logic [17:0] expect_d2;
  logic [17:0] expect_d3;
  logic [17:0] expect_d4;
  logic [17:0] check_d1;
  logic [17:0] check_d2;
  logic [17:0] check_d3;
  logic [17:0] check_d4;
  logic run_d1;
  logic run_d2;
  logic run_d3;
  logic run_d4;
  // AXI write side
  logic aw_held;
  logic w_held;
  logic [5:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic [31:0] wmask;
  logic [31:0] read_word;
  logic read_hit;
  logic write_hit;
  logic write_hit_q;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] m,
                                        input logic [31:0] d);
    return (old & ~m) | (d & m);
  endfunction

  function automatic logic hit(input logic [5:0] a);
    return a <= bist_pkg::off_run && a[1:0] == 2'h0;
  endfunction

  assign write_hit = hit(aw_addr);
  assign read_hit = hit(s_axi_araddr);

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 6'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      write_hit_q <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        write_hit_q <= write_hit;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  assign s_axi_bresp = write_hit_q ? 2'b00 : 2'b10;

  // Field clears are taken only on all-ones in the addressed field
  logic ctl_write;
  logic [31:0] ctl_new;
  assign ctl_write = do_write && aw_addr == bist_pkg::off_control;
  assign ctl_new = merge(32'h00000000, wmask, w_data);

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      sequence_ctl <= 32'h00000000;
      store_one <= bist_pkg::store_one_reset;
      store_two <= bist_pkg::store_two_reset;
      store_upper <= bist_pkg::store_upper_reset;
      lane_mask <= bist_pkg::mask_reset;
      store_two_lane_select <= 18'h00000;
      lane_scramble <= 18'h00000;
      inversion_rotate_enable <= 1'b0;
      run <= 1'b0;
      lane_half_selector <= 2'h0;
    end else if (do_write) begin
      unique case (aw_addr)
        bist_pkg::off_control: inversion_rotate_enable <=
          w_strb[0] ? w_data[bist_pkg::ctl_rot_bit] : inversion_rotate_enable;
        bist_pkg::off_sequence: sequence_ctl <= merge(sequence_ctl, wmask, w_data) & 32'h03ffffff;
        bist_pkg::off_store_one: store_one <= 24'(merge({8'h00, store_one}, wmask, w_data));
        bist_pkg::off_store_two: store_two <= 24'(merge({8'h00, store_two}, wmask, w_data));
        bist_pkg::off_store_upper: store_upper <= merge(store_upper, wmask, w_data);
        bist_pkg::off_mask: lane_mask <= 18'(merge({14'h0, lane_mask}, wmask, w_data));
        bist_pkg::off_store_two_sel: store_two_lane_select <=
          18'(merge({14'h0, store_two_lane_select}, wmask, w_data));
        bist_pkg::off_scramble: lane_scramble <=
          18'(merge({14'h0, lane_scramble}, wmask, w_data));
        bist_pkg::off_run: begin
          run <= w_strb[0] ? w_data[0] : run;
          lane_half_selector <= w_strb[0] ? w_data[9:8] : lane_half_selector;
        end
        default: ;
      endcase
    end
  end

  // Inversion rotates at each loop end on active lanes only; a write wins
  logic [17:0] rot_next;
  always_comb begin
    int prev;
    prev = 0;
    rot_next = lane_inversion;
    for (int i = 0; i < bist_pkg::lane_count; i++) begin
      if (lane_mask[i]) begin
        prev = i;
        for (int k = 1; k < bist_pkg::lane_count; k++) begin
          if (lane_mask[(i + bist_pkg::lane_count - k) % bist_pkg::lane_count] && prev == i)
            prev = (i + bist_pkg::lane_count - k) % bist_pkg::lane_count;
        end
        rot_next[i] = lane_inversion[prev];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) lane_inversion <= 18'h00000;
    else if (do_write && aw_addr == bist_pkg::off_inversion)
      lane_inversion <= 18'(merge({14'h0, lane_inversion}, wmask, w_data));
    else if (loop_end && inversion_rotate_enable) lane_inversion <= rot_next;
  end

  assign read_word = (s_axi_araddr == bist_pkg::off_control) ?
      {bist_pkg::engine_wide, 4'h0, error_tally, 3'h0, first_error_lane,
       2'h0, inversion_rotate_enable, 5'h00} :
    (s_axi_araddr == bist_pkg::off_sequence) ? sequence_ctl :
    (s_axi_araddr == bist_pkg::off_store_one) ? {8'h00, store_one} :
    (s_axi_araddr == bist_pkg::off_store_two) ? {8'h00, store_two} :
    (s_axi_araddr == bist_pkg::off_store_upper) ? store_upper :
    (s_axi_araddr == bist_pkg::off_mask) ? {14'h0, lane_mask} :
    (s_axi_araddr == bist_pkg::off_inversion) ? {14'h0, lane_inversion} :
    (s_axi_araddr == bist_pkg::off_store_two_sel) ? {14'h0, store_two_lane_select} :
    (s_axi_araddr == bist_pkg::off_scramble) ? {14'h0, lane_scramble} :
    (s_axi_araddr == bist_pkg::off_lane_error) ? {14'h0, lane_error_flags} :
    (s_axi_araddr == bist_pkg::off_run) ? {22'h0, lane_half_selector, 7'h00, run} : 32'h0;

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= read_word;
      s_axi_rresp <= read_hit ? 2'b00 : 2'b10;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  bist_pattern_gen u_gen (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .run(run),
    .sequence_ctl(sequence_ctl),
    .gen(gen),
    .bit_index(bit_index),
    .idle_bit(idle_bit),
    .loop_end(loop_end)
  );

  // Pattern bit per generator
  logic [23:0] mod_word;
  logic [2:0] mod_sel;
  logic [39:0] full_one;
  logic [39:0] full_two;
  logic mod_bit;
  logic const_bit;
  logic [17:0] raw;
  logic [17:0] shaped;
  logic scram_bit;
  assign mod_sel = sequence_ctl[bist_pkg::seq_mod_lo +: 3];
  assign mod_word = (mod_sel == 3'h1) ? bist_pkg::mod_l2 : (mod_sel == 3'h2) ? bist_pkg::mod_l4 :
    (mod_sel == 3'h3) ? bist_pkg::mod_l6 : (mod_sel == 3'h4) ? bist_pkg::mod_l8 :
    (mod_sel == 3'h6) ? bist_pkg::mod_l24 : 24'h000000;
  assign full_one = {store_upper[15:0], store_one};
  assign full_two = {store_upper[31:16], store_two};
  assign mod_bit = mod_word[5'(bit_index)];
  assign const_bit = sequence_ctl[bist_pkg::seq_const_bit];
  assign scram_bit = scram_state[22] ^ scram_state[17];

  // Narrow engine drives all lanes as the wide one does; each lane applies its own select, inversion and scramble bits
  always_comb begin
    for (int i = 0; i < bist_pkg::lane_count; i++) begin
      unique case (gen)
        bist_pkg::gen_buffer: raw[i] = store_two_lane_select[i] ? full_two[bit_index] :
          full_one[bit_index];
        bist_pkg::gen_modulo: raw[i] = mod_bit;
        default: raw[i] = const_bit;
      endcase
    end
  end
  assign shaped = ((raw & lane_mask) ^ (lane_inversion & lane_mask))
    ^ (lane_scramble & {18{scram_bit}});

  always_ff @(posedge sys_clk) begin
    if (!nrst || !run) scram_state <= bist_pkg::scramble_seed;
    else if (!idle_bit) scram_state <= {scram_state[21:0], scram_bit};
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      tx_lanes <= 18'h00000;
      rx_meta <= 18'h00000;
      rx_sync <= 18'h00000;
      expect_d1 <= 18'h00000;
      expect_d2 <= 18'h00000;
      expect_d3 <= 18'h00000;
      expect_d4 <= 18'h00000;
      check_d1 <= 18'h00000;
      check_d2 <= 18'h00000;
      check_d3 <= 18'h00000;
      check_d4 <= 18'h00000;
      run_d1 <= 1'b0;
      run_d2 <= 1'b0;
      run_d3 <= 1'b0;
      run_d4 <= 1'b0;
    end else begin
      tx_lanes <= run ? shaped : 18'h00000;
      rx_meta <= rx_lanes;
      rx_sync <= rx_meta;
      expect_d1 <= shaped;
      // Four stages cover the output flop, a one-cycle echo and the two sync flops
      expect_d2 <= expect_d1;
      expect_d3 <= expect_d2;
      expect_d4 <= expect_d3;
      check_d1 <= (run && !idle_bit) ? lane_mask : 18'h00000;
      check_d2 <= check_d1;
      check_d3 <= check_d2;
      check_d4 <= check_d3;
      run_d1 <= run;
      run_d2 <= run_d1;
      run_d3 <= run_d2;
      run_d4 <= run_d3;
    end
  end

  // Narrow engine on a wide link checks only the selected portion
  logic [17:0] portion;
  assign portion = !narrow_engine ? 18'h3ffff :
    (link_width == 2'h1) ? (lane_half_selector[1] ? 18'h3fe00 : 18'h001ff) :
    (link_width == 2'h2) ? (lane_half_selector[0] ? 18'h3fe00 : 18'h001ff) : 18'h3ffff;
  logic [17:0] lane_fail;
  assign lane_fail = (rx_sync ^ expect_d4) & check_d4 & portion & {18{run_d4}};

  bist_lane_error u_err (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .lane_fail(lane_fail),
    .clear_lane(ctl_write && ctl_new[bist_pkg::ctl_lane_lo +: 5] == bist_pkg::lane_ones),
    .clear_tally(ctl_write && ctl_new[bist_pkg::ctl_tally_lo +: 11] == bist_pkg::tally_max),
    .flags_write(do_write && aw_addr == bist_pkg::off_lane_error),
    .flags_wdata(18'(merge({14'h0, lane_error_flags}, wmask, w_data))),
    .first_error_lane(first_error_lane),
    .error_tally(error_tally),
    .lane_error_flags(lane_error_flags)
  );

  a_mask_zero_tx: assert property (@(posedge sys_clk) disable iff (!nrst)
    run && lane_scramble == 18'h0 ##1 1'b1 |-> ((tx_lanes & ~$past(lane_mask)) == 18'h0))
    else $error("masked lane not zero");
  a_width_read: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_axi_rvalid && $past(s_axi_araddr) == bist_pkg::off_control && $rose(s_axi_rvalid)
    |-> s_axi_rdata[31] == bist_pkg::engine_wide) else $error("width bit wrong");
  c_loop_done: cover property (@(posedge sys_clk) loop_end);
  c_error_seen: cover property (@(posedge sys_clk) |lane_fail);
  c_rotate: cover property (@(posedge sys_clk) loop_end && inversion_rotate_enable);
endmodule

// file: sim/link_lane_bist_engine_test.sv
// Purpose: Register and loopback checks of the lane self-test engine
// Assumes: Loopback partner, narrow engine off until the last scenario
// Notes: Handshakes are taken at the rising edge where valid and ready meet
`timescale 1ns/1ps
module link_lane_bist_engine_test;
  logic sys_clk, nrst, tx_seen;
  logic [5:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [17:0] tx_lanes, rx_lanes, flip;
  logic narrow_engine;
  logic [1:0] link_width;
  int fails, tests_run;
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  link_lane_bist_engine link_lane_bist_engine_inst (.sys_clk(sys_clk), .nrst(nrst),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .narrow_engine(narrow_engine),
    .link_width(link_width), .tx_lanes(tx_lanes), .rx_lanes(rx_lanes));
  link_partner_model link_partner_model_inst (.sys_clk(sys_clk), .tx_lanes(tx_lanes),
    .flip(flip), .rx_lanes(rx_lanes));
  task give_verdict;
    if (fails == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Values read right after a rising edge are those the design sampled there
  task wr(input logic [5:0] a, input logic [31:0] d);
    logic hb;
    int n;
    hb = 1'b0;
    n = 0;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!hb && n < 50) begin
      @(posedge sys_clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      hb = (s_axi_bvalid === 1'b1);
      n++;
    end
    s_axi_bready <= 1'b0;
    if (!hb) begin
      fails++;
      $display("wrong value at %0t: no write response", $time);
    end
  endtask
  task rdr(input logic [5:0] a);
    logic hr;
    int n;
    hr = 1'b0;
    n = 0;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!hr && n < 50) begin
      @(posedge sys_clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      hr = (s_axi_rvalid === 1'b1);
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      n++;
    end
    s_axi_rready <= 1'b0;
    if (!hr) begin
      fails++;
      $display("wrong value at %0t: no read response", $time);
    end
  endtask
  initial begin
    nrst = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 44'h0;
    s_axi_wstrb = 4'hf;
    flip = 18'h00000;
    narrow_engine = 1'b0;
    link_width = 2'h0;
    repeat (16) @(posedge sys_clk);
    nrst <= 1'b1;
    rdr(bist_pkg::off_control);
    chk(rd, {bist_pkg::engine_wide, 31'h0});
    rdr(bist_pkg::off_mask);
    chk(rd, 32'h0003ffff);
    rdr(6'h2c);
    chk({30'h0, rsp}, 32'h00000002);
    wr(bist_pkg::off_sequence, 32'h00202408);
    wr(bist_pkg::off_mask, 32'h0001ffff);
    wr(bist_pkg::off_run, 32'h00000001);
    tx_seen = 1'b0;
    flip <= 18'h20000;
    repeat (200) begin
      @(negedge sys_clk);
      tx_seen = tx_seen | (tx_lanes[17] !== 1'b0);
    end
    chk(tx_seen, 32'h0);
    @(posedge sys_clk);
    flip <= 18'h00000;
    rdr(bist_pkg::off_lane_error);
    chk(rd, 32'h0);
    wr(bist_pkg::off_mask, 32'h0003ffff);
    @(posedge sys_clk);
    flip <= 18'h20008;
    repeat (200) @(posedge sys_clk);
    flip <= 18'h00000;
    repeat (5) @(posedge sys_clk);
    rdr(bist_pkg::off_control);
    chk(rd[12:8], 32'h11);
    chk(rd[26:16] == 11'h0, 32'h0);
    rdr(bist_pkg::off_lane_error);
    chk(rd, 32'h00020008);
    wr(bist_pkg::off_control, 32'h07ff1f00);
    rdr(bist_pkg::off_control);
    chk(rd, {bist_pkg::engine_wide, 31'h0});
    wr(bist_pkg::off_lane_error, 32'h0);
    rdr(bist_pkg::off_lane_error);
    chk(rd, 32'h0);
    wr(bist_pkg::off_store_two_sel, 32'h00000f0f);
    wr(bist_pkg::off_scramble, 32'h000300ff);
    wr(bist_pkg::off_inversion, 32'h00000201);
    wr(bist_pkg::off_control, 32'h00000020);
    // About five loops pass, so the rotated pattern differs from the one written
    repeat (400) @(posedge sys_clk);
    rdr(bist_pkg::off_lane_error);
    chk(rd, 32'h0);
    rdr(bist_pkg::off_inversion);
    chk(rd[17:0] != 18'h00201 && rd[17:9] == rd[8:0] && rd[8:0] != 9'h000, 32'h1);
    rdr(bist_pkg::off_control);
    chk(rd[bist_pkg::ctl_rot_bit], 32'h1);
    @(posedge sys_clk);
    narrow_engine <= 1'b1;
    link_width <= 2'h1;
    flip <= 18'h20001;
    repeat (50) @(posedge sys_clk);
    flip <= 18'h00000;
    repeat (5) @(posedge sys_clk);
    rdr(bist_pkg::off_lane_error);
    chk(rd, 32'h00000001);
    give_verdict;
  end
  // Whole run is near 1000 cycles; the limit leaves wide margin
  initial begin
    #100000;
    fails++;
    $display("wrong value at %0t: watchdog expired", $time);
    give_verdict;
  end
endmodule

// file: sim/link_partner_model.sv
// Purpose: Far side of the lane self-test link, looping lanes back
// Assumes: Partner echoes every lane one cycle later
// Notes: flip inverts chosen lanes to fake line errors
`timescale 1ns/1ps
module link_partner_model (
  input wire logic sys_clk,
  input wire logic [17:0] tx_lanes,
  input wire logic [17:0] flip,
  output logic [17:0] rx_lanes
);
  initial rx_lanes = 18'h00000;
  // Echo loops the sequence back unchanged except on lanes set in flip
  always @(posedge sys_clk) begin
    rx_lanes <= tx_lanes ^ flip;
  end
endmodule
